/* hdl/hsdrc_pkg.sv */
package hsdrc_pkg;

  // ****************************************
  // Bus geometry and answers
  // ****************************************
  localparam int          ADDR_W      = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [7:0]        IDX_RIGHT_GAIN  = 8'h42;
  localparam logic [7:0]        IDX_HEADSET     = 8'h43;
  localparam logic [7:0]        IDX_COMP_ONE    = 8'h44;
  localparam logic [7:0]        IDX_COMP_TWO    = 8'h45;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT_GAIN = {2'h0, IDX_RIGHT_GAIN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_HEADSET    = {2'h0, IDX_HEADSET, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_COMP_ONE   = {2'h0, IDX_COMP_ONE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_COMP_TWO   = {2'h0, IDX_COMP_TWO, 2'h0};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HS_EN_BIT    = 7;
  localparam int HS_STAT_LSB  = 5;
  localparam int HS_INS_LSB   = 2;
  localparam int HS_BTN_LSB   = 0;
  localparam int CMP_RSV_BIT  = 7;
  localparam int CMP_LEN_BIT  = 6;
  localparam int CMP_REN_BIT  = 5;
  localparam int CMP_THR_LSB  = 2;
  localparam int CMP_HYS_LSB  = 0;
  localparam int HOLD_RO_BIT  = 7;
  localparam int HOLD_LSB     = 3;
  localparam int HOLD_RSV_LSB = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_RIGHT_GAIN = 8'h00;
  localparam logic [7:0] RST_HEADSET    = 8'h00;
  localparam logic [7:0] RST_COMP_ONE   = 8'h0f;
  localparam logic [7:0] RST_COMP_TWO   = 8'h38;

  // ****************************************
  // Status codes
  // ****************************************
  localparam logic [1:0] HS_NONE  = 2'h0;
  localparam logic [1:0] HS_PLAIN = 2'h1;
  localparam logic [1:0] HS_MIC   = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ_DEF   = 40_000_000;
  localparam int REF_HZ_DEF   = 1_000_000;
  localparam int REF_PER_MS   = 1000;
  localparam int MS_CNT_W     = 6;
  localparam int DEB_CNT_W    = 5;
  // Insertion window and sample period in ms, by code 000..101
  localparam int INS_WIN_MS [6] = '{16, 32, 64, 128, 256, 512};
  localparam int INS_SMP_MS [6] = '{2, 4, 8, 8, 32, 64};
  // Button window and sample period in ms, by code 01..11
  localparam int BTN_WIN_MS [3] = '{8, 16, 32};
  localparam int BTN_SMP_MS [3] = '{1, 2, 4};

  // ****************************************
  // Compression scaling
  // ****************************************
  localparam int         THR_STEP_DB   = 3;
  localparam int         HOLD_BASE_WC  = 32;
  localparam int         HOLD_LONG_WC  = 32768;
  localparam logic [3:0] HOLD_CODE_X4  = 4'he;
  localparam logic [3:0] HOLD_CODE_X5  = 4'hf;
  localparam int         HOLD_W        = 18;

endpackage

/* hdl/debounce_if.sv */
`timescale 1ns/100ps
// Link between the register block and one debounce filter
interface debounce_if #(
  parameter int W = 1
);
  logic [W-1:0]                   raw;     // Level to be filtered
  logic                           sample;  // Sampling tick
  logic                           clear;   // Force idle
  logic [hsdrc_pkg::DEB_CNT_W-1:0] need;   // Agreeing samples required
  logic [W-1:0]                   stable;  // Filtered level

  modport ctl (output raw, output sample, output clear, output need, input stable);
  modport deb (input raw, input sample, input clear, input need, output stable);
endinterface

/* hdl/debounce_filter.sv */
`timescale 1ns/100ps
module debounce_filter
  import hsdrc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  debounce_if.deb   dbus
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [W-1:0]         stable;  // Accepted level
    logic [DEB_CNT_W-1:0] cnt;     // Agreeing samples so far
  } deb_state_type;

  deb_state_type st_ff;   // Registered state
  deb_state_type nxt_st;  // Next state

  if (W < 1) begin : g_chk
    $error("debounce_filter: width must be at least one");
  end

  assign dbus.stable = st_ff.stable;

  // Next state: a change is taken only after enough agreeing samples
  always_comb begin
    nxt_st = st_ff;
    if (dbus.clear) begin
      // Idle, so a re-enable starts from nothing detected
      nxt_st = '0;
    end else if (dbus.sample) begin
      if (dbus.raw == st_ff.stable) begin
        // Glitch ended, restart the window
        nxt_st.cnt = '0;
      end else if (st_ff.cnt + 1'b1 >= dbus.need) begin
        nxt_st.stable = dbus.raw;
        nxt_st.cnt    = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  // Register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* hdl/playback_gain_drc_headset_regs.sv */
`timescale 1ns/100ps
module playback_gain_drc_headset_regs
  import hsdrc_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF,
  parameter int REF_HZ = REF_HZ_DEF
) (
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  input  wire  logic [ADDR_W-1:0] awaddr,
  input  wire  logic [2:0]        awprot,
  input  wire  logic              awvalid,
  output logic                    awready,
  input  wire  logic [31:0]       wdata,
  input  wire  logic [3:0]        wstrb,
  input  wire  logic              wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire  logic              bready,
  input  wire  logic [ADDR_W-1:0] araddr,
  input  wire  logic [2:0]        arprot,
  input  wire  logic              arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire  logic              rready,
  input  wire  logic              headset_plug_raw,
  input  wire  logic              headset_mic_raw,
  input  wire  logic              button_raw,
  output logic signed [7:0]       right_gain,
  output logic                    drc_left_en,
  output logic                    drc_right_en,
  output logic signed [5:0]       drc_threshold_db,
  output logic [1:0]              drc_hysteresis_db,
  output logic [HOLD_W-1:0]       drc_hold_words,
  output logic [1:0]              headset_status,
  output logic                    button_pressed,
  output logic                    button_event
);

  localparam int REF_DIV = CLK_HZ / REF_HZ;

  // Reference divider needs a whole ratio of at least two
  if (REF_DIV < 2 || (CLK_HZ % REF_HZ) != 0) begin : g_chk
    $error("playback_gain_drc_headset_regs: clock must be a multiple of the reference");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]              gain;       // Right playback gain
    logic [7:0]              headset;    // Headset control, status bits unused
    logic [7:0]              comp_one;   // Compression control one
    logic [7:0]              comp_two;   // Compression control two
    logic [ADDR_W-1:0]       aw_addr;    // Held write address
    logic                    aw_held;    // Write address taken
    logic [7:0]              w_byte;     // Held write data, low lane
    logic                    w_lane;     // Low lane strobe held
    logic                    w_held;     // Write data taken
    logic                    bvalid;     // Write answer pending
    logic [1:0]              bresp;      // Write answer code
    logic                    rvalid;     // Read answer pending
    logic [1:0]              rresp;      // Read answer code
    logic [7:0]              rdata;      // Read answer byte
    logic [$clog2(REF_DIV)-1:0] ref_cnt; // Reference divider
    logic [9:0]              us_cnt;     // Reference ticks within a ms
    logic [MS_CNT_W-1:0]     ms_cnt;     // Free ms count for sample ticks
    logic                    ms_tick;    // One-cycle ms pulse
    logic signed [5:0]       thr_db;     // Decoded threshold
    logic [HOLD_W-1:0]       hold_wc;    // Decoded hold length
    logic                    btn_last;   // Previous filtered button
    logic                    btn_evt;    // Press event pulse
  } regs_state_type;

  regs_state_type st_ff;   // Registered state
  regs_state_type nxt_st;  // Next state

  debounce_if #(.W(2)) hs_bus ();   // Insertion filter link
  debounce_if #(.W(1)) btn_bus ();  // Button filter link

  logic                    ref_tick;      // 1 MHz enable
  logic                    hs_enabled;    // Detection on
  logic [2:0]              ins_code;      // Insertion debounce code
  logic [1:0]              btn_code;      // Button debounce code
  logic [ADDR_W-1:0]       wr_addr;       // Effective write address
  logic [7:0]              wr_byte;       // Effective write byte
  logic                    wr_lane;       // Effective low-lane strobe
  logic                    wr_go;         // Both halves of a write present
  logic [7:0]              rd_byte;       // Decoded read byte
  logic                    rd_hit;        // Read address mapped
  logic [1:0]              hs_now;        // Status as seen by software

  // ****************************************
  // Timebase
  // ****************************************
  // One-cycle enables only; no derived clocks
  assign ref_tick = (st_ff.ref_cnt == ($clog2(REF_DIV))'(REF_DIV - 1));

  // Sample tick for a period of 2**k ms, on the ms edge closing it
  function automatic logic ms_period_tick(input logic tick,
                                          input logic [MS_CNT_W-1:0] cnt,
                                          input int per_ms);
    logic [MS_CNT_W-1:0] mask;
    mask = MS_CNT_W'(per_ms - 1);
    return tick && ((cnt & mask) == mask);
  endfunction

  // ****************************************
  // Headset detection control
  // ****************************************
  assign hs_enabled = st_ff.headset[HS_EN_BIT];
  assign ins_code   = st_ff.headset[HS_INS_LSB +: 3];
  assign btn_code   = st_ff.headset[HS_BTN_LSB +: 2];
  // Mic only counts with a plug, so the reserved 10 never shows
  assign hs_bus.raw = {headset_plug_raw & headset_mic_raw, headset_plug_raw};
  assign hs_bus.clear = !hs_enabled;
  assign btn_bus.raw  = button_raw;
  assign btn_bus.clear = !hs_enabled;

  // Insertion window and sample rate; reserved codes act as the longest
  always_comb begin
    int idx;
    idx = (ins_code > 3'h5) ? 5 : int'(ins_code);
    hs_bus.sample = ms_period_tick(st_ff.ms_tick, st_ff.ms_cnt, INS_SMP_MS[idx]);
    hs_bus.need   = DEB_CNT_W'(INS_WIN_MS[idx] / INS_SMP_MS[idx]);
  end

  // Button window; code 00 follows the pin every clock
  always_comb begin
    int idx;
    idx = (btn_code == 2'h0) ? 0 : int'(btn_code) - 1;
    if (btn_code == 2'h0) begin
      btn_bus.sample = 1'b1;
      btn_bus.need   = DEB_CNT_W'(1);
    end else begin
      btn_bus.sample = ms_period_tick(st_ff.ms_tick, st_ff.ms_cnt, BTN_SMP_MS[idx]);
      btn_bus.need   = DEB_CNT_W'(BTN_WIN_MS[idx] / BTN_SMP_MS[idx]);
    end
  end

  assign hs_now = hs_enabled ? hs_bus.stable : HS_NONE;

  debounce_filter #(.W(2)) u_hs_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dbus    (hs_bus.deb)
  );

  debounce_filter #(.W(1)) u_btn_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dbus    (btn_bus.deb)
  );

  // ****************************************
  // Bus write path
  // ****************************************
  // Halves taken now or earlier; order between them is free
  assign wr_addr = st_ff.aw_held ? st_ff.aw_addr : awaddr;
  assign wr_byte = st_ff.w_held ? st_ff.w_byte : wdata[7:0];
  assign wr_lane = st_ff.w_held ? st_ff.w_lane : wstrb[0];
  assign wr_go   = (st_ff.aw_held || (awvalid && awready)) &&
                   (st_ff.w_held || (wvalid && wready));
  // A new half is refused while its slot is full or an answer waits
  assign awready = !st_ff.aw_held && !st_ff.bvalid;
  assign wready  = !st_ff.w_held && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;

  // ****************************************
  // Bus read decode
  // ****************************************
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (araddr == ADDR_RIGHT_GAIN) begin
      rd_byte = st_ff.gain;
    end else if (araddr == ADDR_HEADSET) begin
      rd_byte = st_ff.headset;
      rd_byte[HS_STAT_LSB +: 2] = hs_now;
    end else if (araddr == ADDR_COMP_ONE) begin
      rd_byte = st_ff.comp_one;
    end else if (araddr == ADDR_COMP_TWO) begin
      rd_byte = st_ff.comp_two;
    end else begin
      // Unmapped: zero data with a slave error
      rd_hit = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;

    // Timebase counters
    nxt_st.ms_tick = 1'b0;
    if (ref_tick) begin
      nxt_st.ref_cnt = '0;
      if (st_ff.us_cnt == 10'(REF_PER_MS - 1)) begin
        nxt_st.us_cnt  = '0;
        nxt_st.ms_cnt  = st_ff.ms_cnt + 1'b1;
        nxt_st.ms_tick = 1'b1;
      end else begin
        nxt_st.us_cnt = st_ff.us_cnt + 1'b1;
      end
    end else begin
      nxt_st.ref_cnt = st_ff.ref_cnt + 1'b1;
    end

    // Capture write halves that arrive alone
    if (awvalid && awready && !wr_go) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && wready && !wr_go) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_byte = wdata[7:0];
      nxt_st.w_lane = wstrb[0];
    end

    // Perform the write once both halves are present
    if (wr_go) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = RESP_OKAY;
      if (wr_addr == ADDR_RIGHT_GAIN) begin
        if (wr_lane) begin
          nxt_st.gain = wr_byte;
        end
      end else if (wr_addr == ADDR_HEADSET) begin
        if (wr_lane) begin
          nxt_st.headset = wr_byte;
          nxt_st.headset[HS_STAT_LSB +: 2] = 2'h0;
        end
      end else if (wr_addr == ADDR_COMP_ONE) begin
        if (wr_lane) begin
          nxt_st.comp_one = wr_byte;
        end
      end else if (wr_addr == ADDR_COMP_TWO) begin
        if (wr_lane) begin
          nxt_st.comp_two = wr_byte;
          nxt_st.comp_two[HOLD_RO_BIT] = RST_COMP_TWO[HOLD_RO_BIT];
        end
      end else begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end else if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Read: data captured at the address edge
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_byte;
      nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // Threshold: -3 dB per code step below -3 dB
    nxt_st.thr_db = -6'(THR_STEP_DB) *
                    (6'(st_ff.comp_one[CMP_THR_LSB +: 3]) + 6'h01);

    // Hold length in word clocks; zero means hold disabled
    case (st_ff.comp_two[HOLD_LSB +: 4])
      4'h0: begin
        nxt_st.hold_wc = '0;
      end
      HOLD_CODE_X4: begin
        nxt_st.hold_wc = HOLD_W'(4 * HOLD_LONG_WC);
      end
      HOLD_CODE_X5: begin
        nxt_st.hold_wc = HOLD_W'(5 * HOLD_LONG_WC);
      end
      default: begin
        // Doubling per code from 32 word clocks
        nxt_st.hold_wc = HOLD_W'(HOLD_BASE_WC) <<
                         (st_ff.comp_two[HOLD_LSB +: 4] - 4'h1);
      end
    endcase

    // Button press event on the filtered rising edge
    nxt_st.btn_last = btn_bus.stable;
    nxt_st.btn_evt  = btn_bus.stable && !st_ff.btn_last && hs_enabled;
  end

  // ****************************************
  // Register
  // ****************************************
  // Synchronous reset loads documented defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff          <= '0;
      st_ff.gain     <= RST_RIGHT_GAIN;
      st_ff.headset  <= RST_HEADSET;
      st_ff.comp_one <= RST_COMP_ONE;
      st_ff.comp_two <= RST_COMP_TWO;
      // Decoded outputs follow the reset codes, not separate numbers
      st_ff.thr_db   <= -6'(THR_STEP_DB) * (6'(RST_COMP_ONE[CMP_THR_LSB +: 3]) + 6'h01);
      st_ff.hold_wc  <= HOLD_W'(HOLD_BASE_WC) << (RST_COMP_TWO[HOLD_LSB +: 4] - 4'h1);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bvalid            = st_ff.bvalid;
  assign bresp             = st_ff.bresp;
  assign rvalid            = st_ff.rvalid;
  assign rresp             = st_ff.rresp;
  assign rdata             = {24'h00_0000, st_ff.rdata};
  assign right_gain        = st_ff.gain;
  assign drc_left_en       = st_ff.comp_one[CMP_LEN_BIT];
  assign drc_right_en      = st_ff.comp_one[CMP_REN_BIT];
  assign drc_threshold_db  = st_ff.thr_db;
  assign drc_hysteresis_db = st_ff.comp_one[CMP_HYS_LSB +: 2];
  assign drc_hold_words    = st_ff.hold_wc;
  assign headset_status    = hs_now;
  assign button_pressed    = btn_bus.stable;
  assign button_event      = st_ff.btn_evt;

  // Protection bits carry no meaning for this slave
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot, wstrb[3:1], wdata[31:8]};

endmodule

/* dv/hsdrc_monitor.sv */
`timescale 1ns/100ps
module hsdrc_monitor
  import hsdrc_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic signed [5:0] drc_threshold_db,
  input wire logic [1:0]        headset_status,
  input wire logic              button_event
);
  // ****************************************
  // Bus handshake and output checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Steps of a transfer: request taken, then answer
  sequence rd_taken;
    arvalid && arready;
  endsequence
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  read_answer_a: assert property (rd_taken |=> rvalid)
    else $error("read answer missing");
  write_answer_a: assert property (wr_taken |=> bvalid)
    else $error("write answer missing");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  busy_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  thr_range_a: assert property ((drc_threshold_db <= -3) && (drc_threshold_db >= -24)
    && (drc_threshold_db % 3 == 0)) else $error("threshold out of range");
  status_code_a: assert property (headset_status != 2'h2)
    else $error("reserved headset status");
  btn_pulse_a: assert property (button_event |=> !button_event)
    else $error("button event too long");
endmodule
bind playback_gain_drc_headset_regs hsdrc_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .drc_threshold_db(drc_threshold_db),
  .headset_status(headset_status), .button_event(button_event));

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench
  import hsdrc_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              plug, mic, btn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata;
  wire  [31:0]       rdata;
  wire  [1:0]        bresp, rresp, headset_status, drc_hysteresis_db;
  wire               awready, wready, bvalid, arready, rvalid;
  wire               drc_left_en, drc_right_en, button_pressed, button_event;
  wire signed [7:0]  right_gain;
  wire signed [5:0]  drc_threshold_db;
  wire [HOLD_W-1:0]  drc_hold_words;
  int                mismatches, num_checks, cyc, n_evt;
  logic [7:0]        d;
  logic [1:0]        r;
  // Gain codes: top, zero, bottom, minus half dB
  localparam logic [7:0] hold_exp_gain [4] = '{8'h30, 8'h00, 8'h81, 8'hff};
  // Slower core clock: 1 ms is 2000 cycles, keeps debounce runs short
  playback_gain_drc_headset_regs #(.CLK_HZ(2_000_000), .REF_HZ(1_000_000)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .headset_plug_raw(plug), .headset_mic_raw(mic), .button_raw(btn),
    .right_gain(right_gain), .drc_left_en(drc_left_en), .drc_right_en(drc_right_en),
    .drc_threshold_db(drc_threshold_db), .drc_hysteresis_db(drc_hysteresis_db),
    .drc_hold_words(drc_hold_words), .headset_status(headset_status),
    .button_pressed(button_pressed), .button_event(button_event));
  // ****************************************
  // Clock, timeout and event counting
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Tests wait about 33 ms in all, so 90000 cycles is ample
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (button_event === 1'b1) n_evt <= n_evt + 1;
    if (cyc == 90000) begin
      mismatches++;
      $display("[ERR] %0t run hung", $time);
      close_out();
    end
  end
  // ****************************************
  // Bus tasks: sample before the edge, act after it
  // ****************************************
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid & bready;
      rs = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [7:0] v, output logic [1:0] rs);
    logic ar_t, r_t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid & rready;
      v = rdata[7:0];
      rs = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // ****************************************
  // Compare tasks and verdict
  // ****************************************
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t register got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t response got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_sig(input logic [17:0] g, input logic [17:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t output got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hold length in word clocks for a hold code
  function automatic logic [17:0] hold_exp(input int c);
    if (c == 0) return 18'h0_0000;
    if (c == 14) return 18'(4 * 32768);
    if (c == 15) return 18'(5 * 32768);
    return 18'(32 << (c - 1));
  endfunction
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, plug, mic, btn} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus_rd(ADDR_RIGHT_GAIN, d, r); chk_reg(d, 8'h00);
    bus_rd(ADDR_HEADSET, d, r); chk_reg(d, 8'h00);
    bus_rd(ADDR_COMP_ONE, d, r); chk_reg(d, 8'h0f);
    bus_rd(ADDR_COMP_TWO, d, r); chk_reg(d, 8'h38);
    chk_sig({12'h000, drc_threshold_db}, 18'h0_0034);
    chk_sig({16'h0000, drc_hysteresis_db}, 18'h0_0003);
    chk_sig(drc_hold_words, 18'h0_0800);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      bus_wr(ADDR_RIGHT_GAIN, hold_exp_gain[i], r);
      chk_resp(r, RESP_OKAY);
      bus_rd(ADDR_RIGHT_GAIN, d, r); chk_reg(d, hold_exp_gain[i]);
      chk_sig({10'h000, right_gain}, {10'h000, hold_exp_gain[i]});
    end
    $display("test gain done");
    for (int i = 0; i < 8; i++) begin
      d = {1'b0, i[0], i[1], i[2:0], i[1:0]};
      bus_wr(ADDR_COMP_ONE, d, r);
      bus_rd(ADDR_COMP_ONE, d, r); chk_reg(d, {1'b0, i[0], i[1], i[2:0], i[1:0]});
      chk_sig({16'h0000, drc_left_en, drc_right_en}, {16'h0000, i[0], i[1]});
      chk_sig({12'h000, drc_threshold_db}, {12'h000, 6'(-3 * (i + 1))});
      chk_sig({16'h0000, drc_hysteresis_db}, {16'h0000, i[1:0]});
    end
    $display("test compression done");
    for (int i = 0; i < 16; i++) begin
      bus_wr(ADDR_COMP_TWO, {1'b0, i[3:0], 3'h0}, r);
      bus_rd(ADDR_COMP_TWO, d, r); chk_reg(d, {1'b0, i[3:0], 3'h0});
      chk_sig(drc_hold_words, hold_exp(i));
    end
    $display("test hold done");
    bus_wr(ADDR_HEADSET, 8'he0, r);
    bus_rd(ADDR_HEADSET, d, r); chk_reg(d, 8'h80);
    btn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_sig({17'h0_0000, button_pressed}, 18'h0_0001);
    chk_sig(18'(n_evt), 18'h0_0001);
    plug <= 1'b1;
    mic <= 1'b1;
    repeat (24000) @(posedge aclk);
    chk_sig({16'h0000, headset_status}, {16'h0000, HS_NONE});
    repeat (24000) @(posedge aclk);
    chk_sig({16'h0000, headset_status}, {16'h0000, HS_MIC});
    bus_rd(ADDR_HEADSET, d, r); chk_reg(d, 8'he0);
    bus_wr(ADDR_HEADSET, 8'h00, r);
    chk_sig({16'h0000, headset_status}, {16'h0000, HS_NONE});
    // Button code 01: eight 1 ms samples before the press is taken
    bus_wr(ADDR_HEADSET, 8'h81, r);
    repeat (12000) @(posedge aclk);
    chk_sig({17'h0_0000, button_pressed}, 18'h0_0000);
    repeat (6000) @(posedge aclk);
    chk_sig({17'h0_0000, button_pressed}, 18'h0_0001);
    chk_sig(18'(n_evt), 18'h0_0002);
    $display("test headset done");
    bus_wr(12'h000, 8'h55, r); chk_resp(r, RESP_SLVERR);
    bus_rd(12'h118, d, r); chk_resp(r, RESP_SLVERR);
    chk_reg(d, 8'h00);
    $display("test unmapped done");
    close_out();
  end
endmodule
